// ---- rtl/iwc_defines.vh ----
// Register map, field positions, reset values and timing counts of the wakeup controller
`ifndef IWC_DEFINES_VH
`define IWC_DEFINES_VH

// Printed offsets are not all multiples of four: each is an index, byte address = 4 * index
`define IWC_IDX_REQ        8'hC8
`define IWC_IDX_ENA        8'hC9
`define IWC_IDX_STK        8'hDF
`define IWC_IDX_OSC        8'hCA
`define IWC_IDX_CORE       8'hCB

// Source bit positions, shared by flags and enables
`define IWC_BIT_PIN        0
`define IWC_BIT_BTMR       4
`define IWC_BIT_TCNT       5
`define IWC_BIT_CONV       7
`define IWC_SRC_MASK       8'hB1

// Stack register fields
`define IWC_BIT_GIE        7
`define IWC_STK_RESET      8'h07

// Oscillator/mode register fields
`define IWC_BIT_OSC_STOP   1
`define IWC_BIT_CLK_MODE   2
`define IWC_BIT_MODE_LO    3
`define IWC_BIT_MODE_HI    4
`define IWC_OSC_MASK       8'h1E

// Core-event register: bit 0 return-from-interrupt
`define IWC_BIT_RETURN_FROM_INTERRUPT       0

// Interrupt vector address
`define IWC_VECTOR         12'h008

// Wakeup settling count in high oscillator clocks
`define IWC_SETTLE_CLKS    2048

`endif

// ---- rtl/iwc_ctrl.v ----
// Interrupt and low-power wakeup controller with an Avalon-MM register slave
`timescale 1ns/1ns
`include "iwc_defines.vh"
// Register words, by index: request flags, enables, stack with global
// enable, oscillator and mode control, and a core-event word whose read
// shows the one-hot state and whose bit 0 write acts as a return.
// Only byte lane 0 carries data; the other lanes read as zero.

module iwc_ctrl #(
    parameter SETTLE_CLKS = `IWC_SETTLE_CLKS,
    parameter PORT_W      = 8
) (
    input  wire              mclk,           // System clock, 250 MHz
    input  wire              rst_n,          // Async reset, active low
    input  wire [9:0]        avs_address,    // Word address (index)
    input  wire              avs_read,       // Read strobe
    input  wire              avs_write,      // Write strobe
    input  wire [31:0]       avs_writedata,  // Write data
    input  wire [3:0]        avs_byteenable, // Byte enables
    output reg  [31:0]       avs_readdata,   // Read data
    output reg               avs_waitrequest,// Wait request
    input  wire [PORT_W-1:0] port_zero_pins, // Wakeup pins, asynchronous
    input  wire              btmr_ovf,       // Basic timer overflow pulse
    input  wire              tcnt_ovf,       // Timer/counter overflow pulse
    input  wire              conv_done,      // Conversion end pulse
    input  wire              btmr_wake_en,   // Basic timer wakeup function on
    input  wire              hosc_tick,      // High oscillator clock enable pulse
    input  wire              return_from_interrupt_exec,      // Core executed return-from-interrupt
    input  wire              irq_ack,        // Core took the vector this cycle
    output reg               irq_req,        // Vector request to the core
    output reg  [11:0]       vector_addr,    // Vector address
    output reg               stack_push,     // Push stack one level, pulse
    output reg               cpu_run,        // Instruction execution allowed
    output reg               sys_clk_low,    // System clock from low oscillator
    output reg               hosc_run,       // High oscillator enable
    output reg               losc_run        // Low oscillator enable
);

    // One-hot states; any other code falls back to normal
    localparam [3:0] ST_NORMAL = 4'b0001;
    localparam [3:0] ST_SLOW   = 4'b0010;
    localparam [3:0] ST_GREEN  = 4'b0100;
    localparam [3:0] ST_SLEEP  = 4'b1000;
    localparam [11:0] SET_MAX  = SETTLE_CLKS - 1;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg [7:0]        req_r;
    reg [7:0]        ena_r;
    reg [7:0]        stk_r;
    reg [7:0]        osc_r;
    reg [3:0]        st_r;
    reg              ret_slow_r;
    reg              settle_r;
    reg [11:0]       cnt_r;
    reg              in_srv_r;
    reg              bus_ack_r;
    reg [PORT_W-1:0] p_s1_r;
    reg [PORT_W-1:0] p_s2_r;
    reg [PORT_W-1:0] p_s3_r;
    reg              pin_prev_r;

    // ------------------------------------------------------------
    // State decode shared by the sequencer and the outputs
    // ------------------------------------------------------------
    wire             run_state = st_r[0] | st_r[1];
    wire             in_green  = st_r[2];
    wire             in_sleep  = st_r[3];

    // Byte lane 0 merge, not called; register writes are gated by avs_byteenable[0]
    function [7:0] merge_b0;
        input [7:0] old_v;
        input [7:0] new_v;
        input       be0;
        begin
            merge_b0 = be0 ? new_v : old_v;
        end
    endfunction

    // Word index compare; the upper two index bits must be zero
    function reg_hit;
        input [9:0] addr;
        input [7:0] idx;
        begin
            reg_hit = (addr == {2'b00, idx});
        end
    endfunction

    wire       acc   = (avs_read | avs_write) & ~bus_ack_r;
    wire       wr    = avs_write & ~bus_ack_r & avs_byteenable[0];
    wire [7:0] wd    = avs_writedata[7:0];
    wire       wr_rq = wr && reg_hit(avs_address, `IWC_IDX_REQ);
    wire       wr_en = wr && reg_hit(avs_address, `IWC_IDX_ENA);
    wire       wr_sk = wr && reg_hit(avs_address, `IWC_IDX_STK);
    wire       wr_os = wr && reg_hit(avs_address, `IWC_IDX_OSC);
    wire       wr_co = wr && reg_hit(avs_address, `IWC_IDX_CORE);

    // ------------------------------------------------------------
    // Pin synchroniser and level change detect
    // ------------------------------------------------------------
    // A change counts only once the second and third stages agree, so a
    // pin caught mid-transition by the first stage never wakes the part.
    // The first stage is read by nothing but the second.
    wire pin_stable  = (p_s2_r == p_s3_r);
    wire pin0        = p_s3_r[0];
    reg  [PORT_W-1:0] p_seen_r;
    wire lvl_change  = pin_stable && (p_s3_r != p_seen_r);
    wire pin_edge    = pin_stable && (pin0 != pin_prev_r);

    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            p_s1_r     <= {PORT_W{1'b0}};
            p_s2_r     <= {PORT_W{1'b0}};
            p_s3_r     <= {PORT_W{1'b0}};
            // Reset values match the idle low pins, so no false edge follows
            // reset; a pin held high at reset is seen as one change.
            p_seen_r   <= {PORT_W{1'b0}};
            pin_prev_r <= 1'b0;
        end
        else
        begin
            p_s1_r <= port_zero_pins;
            p_s2_r <= p_s1_r;
            p_s3_r <= p_s2_r;
            if (pin_stable)
            begin
                p_seen_r   <= p_s3_r;
                pin_prev_r <= pin0;
            end
        end
    end

    // ------------------------------------------------------------
    // Flags, enables, global enable
    // ------------------------------------------------------------
    // The basic timer stops in sleep and the timer/counter outside normal
    // and slow, so their pulses are ignored there rather than trusted to
    // the sources.
    wire       ev_pin  = pin_edge;
    wire       ev_btmr = btmr_ovf & ~in_sleep;
    wire       ev_tcnt = tcnt_ovf & run_state;
    wire       ev_conv = conv_done;
    // sources set flags without regard to enables
    wire [7:0] ev = ({7'd0, ev_pin} << `IWC_BIT_PIN)
                  | ({7'd0, ev_btmr} << `IWC_BIT_BTMR)
                  | ({7'd0, ev_tcnt} << `IWC_BIT_TCNT)
                  | ({7'd0, ev_conv} << `IWC_BIT_CONV);
    wire       take = irq_req & irq_ack;
    wire       return_from_interrupt = return_from_interrupt_exec | (wr_co & wd[`IWC_BIT_RETURN_FROM_INTERRUPT]);

    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            req_r    <= 8'h00;
            ena_r    <= 8'h00;
            stk_r    <= `IWC_STK_RESET;
            in_srv_r <= 1'b0;
        end
        else
        begin
            // An event in the cycle of a software write wins, so a request
            // that arrives while its flag is being cleared is never lost.
            // flag set, cleared only by software; set wins over clear
            req_r <= ((wr_rq ? (wd & `IWC_SRC_MASK) : req_r) | ev) & `IWC_SRC_MASK;
            if (wr_en)
                ena_r <= wd & `IWC_SRC_MASK;
            if (wr_sk)
                stk_r <= wd & 8'h87;
            if (take)
            begin
                stk_r[`IWC_BIT_GIE] <= 1'b0;
                // Three-bit level wraps; nesting past the stack is not caught
                // push one level (stack counts down)
                stk_r[2:0] <= stk_r[2:0] - 3'd1;
                // Blocks nesting even if software sets the global enable
                in_srv_r   <= 1'b1;
            end
            else if (return_from_interrupt && in_srv_r)
            begin
                // exit service, global enable set again
                stk_r[`IWC_BIT_GIE] <= 1'b1;
                stk_r[2:0] <= stk_r[2:0] + 3'd1;
                in_srv_r   <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Operating mode sequencer
    // ------------------------------------------------------------
    // Mode writes are honoured only in normal and slow, where code runs.
    // Code 11 of the mode field is decoded as 00, so the clock-mode bit picks slow or normal.
    // Leaving sleep clears the whole control word, so slow mode and a
    // stopped oscillator are both dropped on wake, as normal mode needs.
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r       <= ST_NORMAL;
            osc_r      <= 8'h00;
            ret_slow_r <= 1'b0;
            settle_r   <= 1'b0;
            cnt_r      <= 12'h000;
        end
        else
        begin
            if (wr_os && run_state)
                osc_r <= wd & `IWC_OSC_MASK;
            case (st_r)
                ST_NORMAL, ST_SLOW:
                begin
                    // mode field decode; 11 treated as 00
                    if (wr_os && wd[`IWC_BIT_MODE_LO] && !wd[`IWC_BIT_MODE_HI])
                    begin
                        st_r <= ST_SLEEP;
                    end
                    else if (wr_os && wd[`IWC_BIT_MODE_HI] && !wd[`IWC_BIT_MODE_LO])
                    begin
                        // ret_slow_r lets the wake return to slow
                        // enter green, remember last mode
                        st_r       <= ST_GREEN;
                        ret_slow_r <= st_r[1];
                    end
                    else if (wr_os && wd[`IWC_BIT_CLK_MODE])
                        st_r <= ST_SLOW;
                    else if (wr_os && !wd[`IWC_BIT_CLK_MODE] && !osc_r[`IWC_BIT_OSC_STOP])
                        // back to normal while oscillator runs
                        st_r <= ST_NORMAL;
                end
                ST_GREEN:
                begin
                    // Clocks keep running in green, so the return is immediate
                    // green wakeup sources; immediate return
                    if (lvl_change || (btmr_wake_en && btmr_ovf))
                    begin
                        st_r <= ret_slow_r ? ST_SLOW : ST_NORMAL;
                        osc_r[`IWC_BIT_MODE_HI] <= 1'b0;
                    end
                end
                ST_SLEEP:
                begin
                    // The high oscillator restarts as soon as settling begins if the stop bit is clear;
                    // the low oscillator and the core stay off until the end.
                    // only port level change leaves sleep
                    if (!settle_r && lvl_change)
                    begin
                        settle_r <= 1'b1;
                        cnt_r    <= 12'h000;
                    end
                    else if (settle_r && hosc_tick)
                    begin
                        if (cnt_r == SET_MAX)
                        begin
                            settle_r <= 1'b0;
                            st_r     <= ST_NORMAL;
                            osc_r    <= 8'h00;
                        end
                        else
                            cnt_r <= cnt_r + 12'd1;
                    end
                end
                default:
                    st_r <= ST_NORMAL;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Core-facing outputs
    // ------------------------------------------------------------
    // Outputs are registered from the state, so they lag it by one cycle;
    // a wake seen at one edge shows on cpu_run at the next.
    // single vector request; gated by global enable
    wire pend = |(req_r & ena_r) && stk_r[`IWC_BIT_GIE] && !in_srv_r;

    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_req     <= 1'b0;
            vector_addr <= `IWC_VECTOR;
            stack_push  <= 1'b0;
            cpu_run     <= 1'b1;
            sys_clk_low <= 1'b0;
            hosc_run    <= 1'b1;
            losc_run    <= 1'b1;
        end
        else
        begin
            // request held off until execution resumes
            irq_req     <= pend && run_state && !take;
            vector_addr <= `IWC_VECTOR;
            stack_push  <= take;
            cpu_run     <= run_state;
            sys_clk_low <= st_r[1] | (in_green & ret_slow_r);
            // stop bit halts only the high oscillator
            hosc_run    <= !(in_sleep && !settle_r) && !osc_r[`IWC_BIT_OSC_STOP];
            losc_run    <= !in_sleep;
        end
    end

    // ------------------------------------------------------------
    // Avalon-MM slave: one wait cycle, then answer
    // ------------------------------------------------------------
    // The request is taken at the edge it is first seen, waitrequest drops
    // for one cycle, and bus_ack_r masks the still-standing request at the
    // next edge so it is not taken twice. Read data stand until the next
    // read, which costs a register but keeps the master free to be slow.
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_ack_r       <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end
        else
        begin
            bus_ack_r       <= acc;
            avs_waitrequest <= ~acc;
            if (acc && avs_read)
            begin
                case (avs_address)
                    {2'b00, `IWC_IDX_REQ}: avs_readdata <= {24'h0, req_r};
                    {2'b00, `IWC_IDX_ENA}: avs_readdata <= {24'h0, ena_r};
                    {2'b00, `IWC_IDX_STK}: avs_readdata <= {24'h0, stk_r};
                    {2'b00, `IWC_IDX_OSC}: avs_readdata <= {24'h0, osc_r};
                    // State word: upper bits read as zero
                    {2'b00, `IWC_IDX_CORE}: avs_readdata <= {28'h0, st_r};
                    default:             avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule

// ---- dv/iwc_ctrl_properties.sv ----
// Port assertions of the wakeup controller
`timescale 1ns/1ns
module iwc_props #(
    parameter SETTLE_CLKS = 2048
) (
    input wire        mclk,            // Clock
    input wire        rst_n,           // Reset
    input wire        avs_read,        // Read
    input wire        avs_write,       // Write
    input wire        avs_waitrequest, // Wait
    input wire        btmr_ovf,        // Timer pulse
    input wire        btmr_wake_en,    // Timer wake
    input wire        hosc_tick,       // Osc tick
    input wire        return_from_interrupt_exec,       // Return
    input wire        irq_ack,         // Take
    input wire        irq_req,         // Request
    input wire [11:0] vector_addr,     // Vector
    input wire        stack_push,      // Push
    input wire        cpu_run,         // Run
    input wire        sys_clk_low,     // Slow clock
    input wire        hosc_run,        // High osc
    input wire        losc_run         // Low osc
);
    reg        slp_r;
    reg        svc_r;
    reg [15:0] tck_r;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    // Sleep seen by the low osc stopping
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            slp_r <= 1'b0;
            svc_r <= 1'b0;
            tck_r <= 16'h0000;
        end
        else
        begin
            slp_r <= cpu_run ? 1'b0 : (slp_r | ~losc_run);
            svc_r <= (irq_req & irq_ack) ? 1'b1 : (return_from_interrupt_exec ? 1'b0 : svc_r);
            tck_r <= slp_r ? tck_r + {15'h0000, hosc_tick} : 16'h0000;
        end
    end
    sequence s_take;
        irq_req && irq_ack;
    endsequence
    sequence s_busreq;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    property p_vec;
        vector_addr == 12'h008;
    endproperty
    property p_take;
        s_take |=> stack_push && !irq_req;
    endproperty
    property p_push;
        stack_push |-> $past(irq_req && irq_ack);
    endproperty
    property p_svc;
        svc_r |-> !irq_req;
    endproperty
    property p_bus;
        s_busreq |-> ##[1:2] !avs_waitrequest;
    endproperty
    property p_one;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    property p_halt;
        $fell(losc_run) |-> !hosc_run && !cpu_run;
    endproperty
    property p_slow;
        !hosc_run && cpu_run |-> sys_clk_low;
    endproperty
    property p_idle;
        !cpu_run && !$past(cpu_run) && !$past(cpu_run, 2) |-> !irq_req;
    endproperty
    property p_settle;
        $rose(cpu_run) && slp_r |-> tck_r >= SETTLE_CLKS;
    endproperty
    property p_green;
        !cpu_run && losc_run && !slp_r && btmr_wake_en && btmr_ovf |-> ##2 cpu_run;
    endproperty
    a_vec: assert property (p_vec) else $error("vector not 8");
    a_take: assert property (p_take) else $error("take did not push");
    a_push: assert property (p_push) else $error("push without take");
    a_svc: assert property (p_svc) else $error("request in service");
    a_bus: assert property (p_bus) else $error("bus not answered");
    a_one: assert property (p_one) else $error("answer too long");
    a_halt: assert property (p_halt) else $error("sleep left clocks on");
    a_slow: assert property (p_slow) else $error("run on stopped clock");
    a_idle: assert property (p_idle) else $error("request while halted");
    a_settle: assert property (p_settle) else $error("short settle");
    a_green: assert property (p_green) else $error("green wake late");
endmodule
bind iwc_ctrl iwc_props #(.SETTLE_CLKS(SETTLE_CLKS)) chk_u (
    .mclk(mclk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .btmr_ovf(btmr_ovf), .btmr_wake_en(btmr_wake_en),
    .hosc_tick(hosc_tick), .return_from_interrupt_exec(return_from_interrupt_exec), .irq_ack(irq_ack), .irq_req(irq_req),
    .vector_addr(vector_addr), .stack_push(stack_push), .cpu_run(cpu_run),
    .sys_clk_low(sys_clk_low), .hosc_run(hosc_run), .losc_run(losc_run));

// ---- dv/iwc_core_model.sv ----
// Core model: takes vectors, returns from service, paces the high osc
`timescale 1ns/1ns
module iwc_core_model #(
    parameter SVC_LEN = 40
) (
    input  wire       mclk,      // Clock
    input  wire       rst_n,     // Reset
    input  wire [7:0] ack_dly,   // Cycles before a take
    input  wire       irq_req,   // Vector request
    output reg        irq_ack,   // Take pulse
    output reg        return_from_interrupt_exec, // Return pulse
    output reg        hosc_tick  // High osc clock
);
    reg [7:0] cnt_r;
    reg       svc_r;
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {cnt_r, svc_r, irq_ack, return_from_interrupt_exec, hosc_tick} <= 12'h000;
        end
        else
        begin
            hosc_tick <= ~hosc_tick;
            irq_ack <= 1'b0;
            return_from_interrupt_exec <= 1'b0;
            cnt_r <= (!svc_r && !irq_req) ? 8'h00 : cnt_r + 8'h01;
            if (!svc_r && irq_req && !irq_ack && cnt_r >= ack_dly)
            begin
                {irq_ack, svc_r, cnt_r} <= {2'b11, 8'h00};
            end
            if (svc_r && cnt_r == SVC_LEN)
            begin
                {return_from_interrupt_exec, svc_r} <= 2'b10;
            end
        end
    end
endmodule

// ---- dv/tb_top.sv ----
// Self-checking bench of the wakeup controller
`timescale 1ns/1ns
`include "iwc_defines.vh"
module tb_top;
    reg         mclk = 1'b0;
    reg         rst_n = 1'b0;
    reg  [9:0]  avs_address = 10'h000;
    reg         avs_read = 1'b0;
    reg         avs_write = 1'b0;
    reg  [31:0] avs_writedata = 32'h00000000;
    reg  [3:0]  avs_byteenable = 4'hF;
    reg  [7:0]  port_zero_pins = 8'h00;
    reg  [2:0]  evs = 3'b000;
    reg         btmr_wake_en = 1'b0;
    reg  [7:0]  ack_dly = 8'h00;
    reg  [31:0] seed = 32'h00000058;
    reg  [31:0] rd;
    wire [31:0] avs_readdata;
    wire [11:0] vector_addr;
    wire        avs_waitrequest, irq_ack, return_from_interrupt_exec, hosc_tick, irq_req, stack_push;
    wire        cpu_run, sys_clk_low, hosc_run, losc_run;
    integer     mismatches = 0;
    integer     tests_run = 0;
    integer     i;
    iwc_ctrl #(.SETTLE_CLKS(8), .PORT_W(8)) dut_u (.mclk(mclk), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .port_zero_pins(port_zero_pins), .btmr_ovf(evs[0]), .tcnt_ovf(evs[1]),
        .conv_done(evs[2]), .btmr_wake_en(btmr_wake_en), .hosc_tick(hosc_tick),
        .return_from_interrupt_exec(return_from_interrupt_exec), .irq_ack(irq_ack), .irq_req(irq_req),
        .vector_addr(vector_addr), .stack_push(stack_push), .cpu_run(cpu_run),
        .sys_clk_low(sys_clk_low), .hosc_run(hosc_run), .losc_run(losc_run));
    iwc_core_model core_u (.mclk(mclk), .rst_n(rst_n), .ack_dly(ack_dly),
        .irq_req(irq_req), .irq_ack(irq_ack), .return_from_interrupt_exec(return_from_interrupt_exec), .hosc_tick(hosc_tick));
    always #2 mclk = ~mclk;
    function [31:0] xs(input [31:0] x);
        begin
            x = x ^ (x << 13);
            x = x ^ (x >> 17);
            xs = x ^ (x << 5);
        end
    endfunction
    task chk(input [63:0] nm, input [31:0] seen, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp)
            begin
                mismatches = mismatches + 1;
                $display("[ERR] %0s exp %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task bus(input wr, input [9:0] a, input [7:0] d);
        integer n;
        begin
            n = 0;
            @(posedge mclk);
            {avs_address, avs_write, avs_read} <= {a, wr, !wr};
            avs_writedata <= {24'h000000, d};
            @(posedge mclk);
            while (avs_waitrequest !== 1'b0)
            begin
                n = n + 1;
                @(posedge mclk);
            end
            rd = avs_readdata;
            {avs_write, avs_read} <= 2'b00;
        end
    endtask
    task rc(input [9:0] a, input [31:0] e, input [63:0] nm);
        begin
            bus(1'b0, a, 8'h00);
            chk(nm, rd, e);
        end
    endtask
    task ev(input [2:0] m);
        begin
            @(posedge mclk);
            evs <= m;
            @(posedge mclk);
            evs <= 3'b000;
            repeat (3) @(posedge mclk);
        end
    endtask
    // Waits for any of return, push, run
    task wfor(input [2:0] s);
        integer n;
        begin
            n = 0;
            while ((({return_from_interrupt_exec, stack_push, cpu_run} & s) == 3'b000) && n < 300)
            begin
                @(posedge mclk);
                n = n + 1;
            end
            if (n >= 300)
                mismatches = mismatches + 1;
        end
    endtask
    task svc(input [7:0] en, input [2:0] m, input [7:0] dly);
        begin
            ack_dly <= dly;
            bus(1'b1, `IWC_IDX_ENA, en);
            bus(1'b1, `IWC_IDX_STK, 8'h87);
            ev(m);
            wfor(3'b010);
            rc(`IWC_IDX_STK, 8'h06, "stk_in");
            rc(`IWC_IDX_REQ, en, "flag_in");
            bus(1'b1, `IWC_IDX_REQ, 8'h00);
            wfor(3'b100);
            rc(`IWC_IDX_STK, 8'h87, "stk_out");
        end
    endtask
    task final_report;
        begin
            if (mismatches == 0 && tests_run > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    initial
    begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        rc(`IWC_IDX_REQ, 0, "flags");
        rc(`IWC_IDX_ENA, 0, "enables");
        rc(`IWC_IDX_STK, `IWC_STK_RESET, "stack");
        rc(10'h100, 0, "unmapped");
        for (i = 0; i < 6; i = i + 1)
        begin
            seed = xs(seed);
            bus(1'b1, `IWC_IDX_ENA, seed[7:0]);
            rc(`IWC_IDX_ENA, seed[7:0] & `IWC_SRC_MASK, "enables");
            bus(1'b1, `IWC_IDX_REQ, seed[15:8]);
            rc(`IWC_IDX_REQ, seed[15:8] & `IWC_SRC_MASK, "flags");
        end
        chk("irq_gie", irq_req, 0);
        bus(1'b1, `IWC_IDX_ENA, 8'h00);
        bus(1'b1, `IWC_IDX_REQ, 8'h00);
        port_zero_pins <= 8'h01;
        ev(3'b111);
        rc(`IWC_IDX_REQ, `IWC_SRC_MASK, "flags");
        avs_byteenable <= 4'h0;
        bus(1'b1, `IWC_IDX_REQ, 8'h00);
        avs_byteenable <= 4'hF;
        rc(`IWC_IDX_REQ, `IWC_SRC_MASK, "flag_be");
        bus(1'b1, `IWC_IDX_REQ, 8'h00);
        svc(8'h80, 3'b100, 8'h00);
        svc(8'h20, 3'b010, 8'h30);
        svc(8'h10, 3'b001, 8'h02);
        bus(1'b1, `IWC_IDX_STK, 8'h07);
        bus(1'b1, `IWC_IDX_OSC, 8'h04);
        bus(1'b1, `IWC_IDX_OSC, 8'h06);
        repeat (3) @(posedge mclk);
        chk("slow", {sys_clk_low, hosc_run, losc_run}, 3'b101);
        bus(1'b1, `IWC_IDX_OSC, 8'h14);
        ev(3'b001);
        chk("green", cpu_run, 0);
        btmr_wake_en <= 1'b1;
        ev(3'b001);
        chk("g_wake", {cpu_run, sys_clk_low}, 2'b11);
        bus(1'b1, `IWC_IDX_OSC, 8'h00);
        bus(1'b1, `IWC_IDX_OSC, 8'h10);
        port_zero_pins <= 8'h03;
        wfor(3'b001);
        bus(1'b1, `IWC_IDX_OSC, 8'h18);
        repeat (3) @(posedge mclk);
        chk("normal", {cpu_run, sys_clk_low}, 2'b10);
        port_zero_pins <= 8'h02;
        repeat (5) @(posedge mclk);
        bus(1'b1, `IWC_IDX_REQ, 8'h00);
        bus(1'b1, `IWC_IDX_ENA, 8'h01);
        bus(1'b1, `IWC_IDX_STK, 8'h87);
        bus(1'b1, `IWC_IDX_OSC, 8'h08);
        ev(3'b001);
        chk("sleep", {cpu_run, losc_run, irq_req}, 3'b000);
        port_zero_pins <= 8'h03;
        wfor(3'b001);
        chk("s_wake", sys_clk_low, 0);
        wfor(3'b010);
        chk("latched", stack_push, 1);
        bus(1'b1, `IWC_IDX_REQ, 8'h00);
        wfor(3'b100);
        final_report;
    end
    initial
    begin
        #80000;
        mismatches = mismatches + 1;
        final_report;
    end
endmodule
